// ### rtl/wk_pkg.sv
package wk_pkg;

    // Register bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Wake enable registers, held through every reset but standby power-on
    localparam logic [ADDR_W-1:0] OFS_P1_EN = 8'h0B;
    localparam logic [ADDR_W-1:0] OFS_P2_EN = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_MIX_EN = 8'h0D;

    // Latched wake status registers, write one to clear
    localparam logic [ADDR_W-1:0] OFS_P1_ST = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_P2_ST = 8'h21;
    localparam logic [ADDR_W-1:0] OFS_MIX_ST = 8'h22;

    // Wake control register holding the master enable
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h23;
    localparam int MASTER_BIT = 0;

    // Reset values
    localparam logic [DATA_W-1:0] EN_RST = 8'h00;
    localparam logic [DATA_W-1:0] ST_RST = 8'h00;
    localparam logic CTRL_RST = 1'h0;
    localparam logic [DATA_W-1:0] RD_IDLE = 8'h00;
    localparam logic OUT_IDLE_N = 1'h1;

    // One byte per source group, port 1 in the low byte
    typedef struct packed {
        logic [DATA_W-1:0] mixed;
        logic [DATA_W-1:0] port2;
        logic [DATA_W-1:0] port1;
    } wk_src_s;

    // One register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } wk_bus_s;

    // Write-one-to-clear update where a new event wins over the clear
    function automatic logic [DATA_W-1:0] wk_w1c(
        input logic [DATA_W-1:0] cur,
        input logic [DATA_W-1:0] clr,
        input logic [DATA_W-1:0] set
    );
        return (cur & ~clr) | set;
    endfunction : wk_w1c

endpackage : wk_pkg

// ### rtl/wk_gpio_wake.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
// Notes on behaviour
// - A source wakes only with its enable, its status and the master at 1.
// - A disabled source still latches status but never drives the output.
// - Enables clear only on standby power-on reset and survive all others.
// - Enable register 0B bits 0 to 7 gate port 1 pins 0 to 7.
// - Enable register 0C bits 0 to 7 gate port 2 pins 0 to 7.
// - 0D bits gate port 3 pins 0-3, port 4 pins 1 and 3, port 6 pins 0, 1.
// - A status bit clears on a written 1, not a 0; software clears it.
// - A status bit is set by its source event whatever the enables say.
module wk_gpio_wake (
    // Clock and standby power-on reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Register port
    input wire wk_pkg::wk_bus_s bus_i,
    output logic [wk_pkg::DATA_W-1:0] rd_data_o,
    // Wake sources and latched status
    input wire wk_pkg::wk_src_s wake_evt_i,
    output wk_pkg::wk_src_s wake_status_o,
    output logic wake_master_enable_o,
    // Power management event to the chipset
    output logic wake_event_out_n_o
);
    import wk_pkg::*;

    wk_src_s en_reg;
    wk_src_s en_next;
    wk_src_s st_reg;
    wk_src_s st_next;
    logic master_reg;
    logic master_next;
    logic [DATA_W-1:0] rd_reg;
    logic [DATA_W-1:0] rd_next;
    logic out_n_reg;
    logic out_n_next;

    // Address decode
    wire hit_p1_en = bus_i.addr == OFS_P1_EN;
    wire hit_p2_en = bus_i.addr == OFS_P2_EN;
    wire hit_mix_en = bus_i.addr == OFS_MIX_EN;
    wire hit_p1_st = bus_i.addr == OFS_P1_ST;
    wire hit_p2_st = bus_i.addr == OFS_P2_ST;
    wire hit_mix_st = bus_i.addr == OFS_MIX_ST;
    wire hit_ctrl = bus_i.addr == OFS_CTRL;

    // Write strobes per register
    wire wr_p1_en = bus_i.wr & hit_p1_en;
    wire wr_p2_en = bus_i.wr & hit_p2_en;
    wire wr_mix_en = bus_i.wr & hit_mix_en;
    wire wr_p1_st = bus_i.wr & hit_p1_st;
    wire wr_p2_st = bus_i.wr & hit_p2_st;
    wire wr_mix_st = bus_i.wr & hit_mix_st;
    wire wr_ctrl = bus_i.wr & hit_ctrl;

    // Clear masks taken from written ones
    // A clear never wins over an event in the same cycle
    wire [DATA_W-1:0] clr_p1 = wr_p1_st ? bus_i.wdata : ST_RST;
    wire [DATA_W-1:0] clr_p2 = wr_p2_st ? bus_i.wdata : ST_RST;
    wire [DATA_W-1:0] clr_mix = wr_mix_st ? bus_i.wdata : ST_RST;

    // Enable registers load only on their own write
    assign en_next.port1 = wr_p1_en ? bus_i.wdata : en_reg.port1;
    assign en_next.port2 = wr_p2_en ? bus_i.wdata : en_reg.port2;
    assign en_next.mixed = wr_mix_en ? bus_i.wdata : en_reg.mixed;
    assign master_next = wr_ctrl ? bus_i.wdata[MASTER_BIT] : master_reg;

    // Status latches every event, ignoring enables; set beats clear
    assign st_next.port1 = wk_w1c(st_reg.port1, clr_p1,
        wake_evt_i.port1);
    assign st_next.port2 = wk_w1c(st_reg.port2, clr_p2,
        wake_evt_i.port2);
    assign st_next.mixed = wk_w1c(st_reg.mixed, clr_mix,
        wake_evt_i.mixed);

    // Gating of latched status onto the wake output
    wire [3*DATA_W-1:0] wake_terms = st_reg & en_reg;
    wire wake_any = master_reg & (|wake_terms);
    assign out_n_next = ~wake_any;

    // Read selection, unmapped addresses read zero
    // Read data is one cycle wide so a stale byte is never seen twice
    wire [DATA_W-1:0] ctrl_view = {{(DATA_W-1){1'h0}}, master_reg};
    wire [DATA_W-1:0] rd_sel =
        hit_p1_en ? en_reg.port1 :
        hit_p2_en ? en_reg.port2 :
        hit_mix_en ? en_reg.mixed :
        hit_p1_st ? st_reg.port1 :
        hit_p2_st ? st_reg.port2 :
        hit_mix_st ? st_reg.mixed :
        hit_ctrl ? ctrl_view : RD_IDLE;
    assign rd_next = bus_i.rd ? rd_sel : RD_IDLE;

    // Enable and control registers; only standby power-on clears them
    // Main-power, soft and host bus resets never reach this block
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            en_reg <= {EN_RST, EN_RST, EN_RST};
            master_reg <= CTRL_RST;
        end else begin
            en_reg <= en_next;
            master_reg <= master_next;
        end
    end

    // Status latches
    // Status also survives every reset but standby power-on
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg <= {ST_RST, ST_RST, ST_RST};
        end else begin
            st_reg <= st_next;
        end
    end

    // Read data and wake output flops
    // A flop on the line keeps gating glitches off the chipset input
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_reg <= RD_IDLE;
            out_n_reg <= OUT_IDLE_N;
        end else begin
            rd_reg <= rd_next;
            out_n_reg <= out_n_next;
        end
    end

    // Outputs
    assign rd_data_o = rd_reg;
    assign wake_status_o = st_reg;
    assign wake_master_enable_o = master_reg;
    assign wake_event_out_n_o = out_n_reg;

    // Checks on the gating and register behaviour
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);
    // Checks sleep while standby reset holds the block

    // Helper terms for the checks
    wire [3*DATA_W-1:0] evt_vec = wake_evt_i;
    wire [3*DATA_W-1:0] en_vec = en_reg;
    wire [3*DATA_W-1:0] st_vec = st_reg;
    wire en_write = wr_p1_en | wr_p2_en | wr_mix_en;

    sequence term_held;
        wake_any [*3];
    endsequence

    sequence no_term;
        !master_reg || ((st_vec & en_vec) == '0);
    endsequence

    out_gate_a: assert property (
        wake_any |=> !wake_event_out_n_o)
        else $error("wake output not asserted for qualified source");

    out_quiet_a: assert property (
        no_term |=> wake_event_out_n_o)
        else $error("wake output asserted without qualified source");

    masked_src_a: assert property (
        (evt_vec != '0) && ((evt_vec & en_vec) == '0)
        && ((st_vec & en_vec) == '0) && !wr_p1_en && !wr_p2_en
        && !wr_mix_en |=> ((st_vec & $past(evt_vec)) == $past(evt_vec))
        ##1 wake_event_out_n_o)
        else $error("disabled source reached wake output");

    enable_keep_a: assert property (
        !en_write |=> $stable(en_reg))
        else $error("enable register changed without a write");

    port1_map_a: assert property (
        wr_p1_en |=> en_reg.port1 == $past(bus_i.wdata)
        && $stable(en_reg.port2))
        else $error("port 1 enable not loaded");

    port2_map_a: assert property (
        wr_p2_en |=> en_reg.port2 == $past(bus_i.wdata)
        && $stable(en_reg.mixed))
        else $error("port 2 enable not loaded");

    mixed_map_a: assert property (
        wr_mix_en |=> en_reg.mixed == $past(bus_i.wdata)
        && $stable(en_reg.port1))
        else $error("mixed enable not loaded");

    status_clear_a: assert property (
        wr_p1_st && (wake_evt_i.port1 == '0) |=>
        ((st_reg.port1 & $past(bus_i.wdata)) == '0)
        && ((st_reg.port1 & ~$past(bus_i.wdata))
        == ($past(st_reg.port1) & ~$past(bus_i.wdata))))
        else $error("status write-one-to-clear misbehaved");

    status_set_a: assert property (
        (evt_vec != '0) |=> ((st_vec & $past(evt_vec)) == $past(evt_vec)))
        else $error("event not latched in status");

    out_hold_a: assert property (
        term_held |-> ##1 !wake_event_out_n_o
        && $past(!wake_event_out_n_o))
        else $error("wake output dropped while term held");

    read_back_a: assert property (
        bus_i.rd && hit_p1_en && !bus_i.wr |=>
        rd_data_o == $past(en_reg.port1) ##1 rd_data_o == RD_IDLE
        || $past(bus_i.rd))
        else $error("read data wrong or not single cycle");

    // Each enable byte gates its own source byte onto the output
    sequence p1_term;
        master_reg && ((st_reg.port1 & en_reg.port1) != '0);
    endsequence

    sequence p2_term;
        master_reg && ((st_reg.port2 & en_reg.port2) != '0);
    endsequence

    sequence mix_term;
        master_reg && ((st_reg.mixed & en_reg.mixed) != '0);
    endsequence

    port1_gate_a: assert property (
        p1_term |=> !wake_event_out_n_o)
        else $error("port 1 source did not reach wake output");

    port2_gate_a: assert property (
        p2_term |=> !wake_event_out_n_o)
        else $error("port 2 source did not reach wake output");

    mixed_gate_a: assert property (
        mix_term |=> !wake_event_out_n_o)
        else $error("mixed source did not reach wake output");

    // Master enable loads only on its own write and blocks the output
    master_off_a: assert property (
        !master_reg |=> wake_event_out_n_o)
        else $error("wake output asserted with master enable off");

    master_load_a: assert property (
        wr_ctrl |=> master_reg == $past(bus_i.wdata[MASTER_BIT]))
        else $error("master enable not loaded");

    master_keep_a: assert property (
        !wr_ctrl |=> $stable(master_reg))
        else $error("master enable changed without a write");

    // Latched sources whose enables are all off leave the line idle
    sequence only_masked;
        (st_vec != '0) && ((st_vec & en_vec) == '0);
    endsequence

    masked_quiet_a: assert property (
        only_masked |=> wake_event_out_n_o)
        else $error("latched disabled source drove wake output");

    // Clears on the other two groups, with no event racing them
    sequence p2_clear_req;
        wr_p2_st && (wake_evt_i.port2 == '0);
    endsequence

    sequence mix_clear_req;
        wr_mix_st && (wake_evt_i.mixed == '0);
    endsequence

    port2_clear_a: assert property (
        p2_clear_req |=> st_reg.port2
        == ($past(st_reg.port2) & ~$past(bus_i.wdata)))
        else $error("port 2 status clear misbehaved");

    mixed_clear_a: assert property (
        mix_clear_req |=> st_reg.mixed
        == ($past(st_reg.mixed) & ~$past(bus_i.wdata)))
        else $error("mixed status clear misbehaved");

    // Without a status write or an event the latch must hold
    status_keep_a: assert property (
        !wr_p1_st && (wake_evt_i.port1 == '0) |=> $stable(st_reg.port1))
        else $error("port 1 status changed on its own");

    // A clear in the same cycle as an event must not lose the event
    set_wins_a: assert property (
        wr_p1_st && ((wake_evt_i.port1 & bus_i.wdata) != '0) |=>
        ((st_reg.port1 & $past(wake_evt_i.port1))
        == $past(wake_evt_i.port1)))
        else $error("clear beat a new event in port 1 status");

    // Every edge of the line follows the gating term one cycle before
    out_fall_a: assert property (
        $fell(wake_event_out_n_o) |-> $past(wake_any))
        else $error("wake output fell without a qualified term");

    out_rise_a: assert property (
        $rose(wake_event_out_n_o) |-> !$past(wake_any))
        else $error("wake output rose while a term was held");

    // Read data for port 1 status and the control register, and idle between reads
    read_status_a: assert property (
        bus_i.rd && hit_p1_st |=> rd_data_o == $past(st_reg.port1))
        else $error("port 1 status read back wrong");

    read_ctrl_a: assert property (
        bus_i.rd && hit_ctrl |=> rd_data_o == $past(ctrl_view))
        else $error("control register read back wrong");

    read_idle_a: assert property (
        !bus_i.rd |=> rd_data_o == RD_IDLE)
        else $error("read data not idle without a read");

endmodule : wk_gpio_wake

// ### testbench/wk_chipset_model.sv
`timescale 1ns/100ps
// Chipset wake input: counts each new wake request on the active-low line
module wk_chipset_model (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Wake line from the block
    input wire logic wake_n_i,
    output int wake_count_o
);
    logic last_n = 1'h1;
    int count = 0;
    // A high to low step is one wake request
    always @(posedge core_clk_i) begin
        if (nrst_i && last_n && !wake_n_i) begin
            count <= count + 1;
        end
        last_n <= wake_n_i;
    end
    assign wake_count_o = count;
endmodule : wk_chipset_model

// ### testbench/tb.sv
`timescale 1ns/100ps
module tb;
    import wk_pkg::*;
    logic core_clk_i = 1'h0;
    logic nrst_i = 1'h0;
    wk_bus_s bus_i = '0;
    wk_src_s wake_evt_i = '0;
    logic [7:0] rd_data_o;
    wk_src_s wake_status_o;
    logic wake_master_enable_o;
    logic wake_event_out_n_o;
    int n_errors = 0;
    int n_tests = 0;
    int seed = 32'hA5008EE4;
    int cycles = 0;
    int wakes;
    logic [31:0] r;
    logic [23:0] m_en = '0;
    logic [23:0] m_st = '0;
    logic m_mst = 1'h0;
    logic m_out_n = 1'h1;
    logic m_prev_n = 1'h1;
    int m_wakes = 0;
    logic [7:0] m_rd = '0;
    logic [7:0] addrs [8] = '{OFS_P1_EN, OFS_P2_EN, OFS_MIX_EN, OFS_P1_ST,
        OFS_P2_ST, OFS_MIX_ST, OFS_CTRL, 8'h30};
    wk_gpio_wake wk_gpio_wake_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .bus_i(bus_i), .rd_data_o(rd_data_o), .wake_evt_i(wake_evt_i),
        .wake_status_o(wake_status_o),
        .wake_master_enable_o(wake_master_enable_o),
        .wake_event_out_n_o(wake_event_out_n_o));
    wk_chipset_model wk_chipset_model_inst (.core_clk_i(core_clk_i),
        .nrst_i(nrst_i), .wake_n_i(wake_event_out_n_o), .wake_count_o(wakes));
    // Clock
    initial forever #2.5 core_clk_i = ~core_clk_i;
    // Read view of the model registers
    function automatic logic [7:0] rd_of(input logic [7:0] a);
        rd_of = 8'h00;
        for (int g = 0; g < 3; g++) begin
            if (a == OFS_P1_EN + g) rd_of = m_en[8*g +: 8];
            if (a == OFS_P1_ST + g) rd_of = m_st[8*g +: 8];
        end
        if (a == OFS_CTRL) rd_of = {7'h00, m_mst};
    endfunction : rd_of
    // Reference model, old register values used before update
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            m_en = '0;
            m_st = '0;
            m_mst = 1'h0;
            m_out_n = 1'h1;
            m_prev_n = 1'h1;
            m_rd = '0;
        end else begin
            // The chipset sees a fall one edge after the line drops
            if (m_prev_n && !m_out_n) m_wakes++;
            m_prev_n = m_out_n;
            m_out_n = !(m_mst && |(m_st & m_en));
            m_rd = bus_i.rd ? rd_of(bus_i.addr) : 8'h00;
            for (int g = 0; g < 3; g++) begin
                if (bus_i.wr && bus_i.addr == OFS_P1_EN + g) begin
                    m_en[8*g +: 8] = bus_i.wdata;
                end
                if (bus_i.wr && bus_i.addr == OFS_P1_ST + g) begin
                    m_st[8*g +: 8] &= ~bus_i.wdata;
                end
            end
            if (bus_i.wr && bus_i.addr == OFS_CTRL) m_mst = bus_i.wdata[0];
            m_st = m_st | wake_evt_i;
        end
    end
    task automatic chk(input string name, input logic [23:0] e, g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask : chk
    task automatic conclude;
        $display("checks %0d errors %0d wakes %0d", n_tests, n_errors, wakes);
        if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude
    // Compare every cycle where outputs are settled
    always @(negedge core_clk_i) begin
        chk("rd_data", m_rd, rd_data_o);
        chk("status", m_st, wake_status_o);
        chk("master", m_mst, wake_master_enable_o);
        chk("wake_out_n", m_out_n, wake_event_out_n_o);
        cycles++;
        if (cycles > 12000) begin
            n_errors++;
            conclude();
        end
    end
    task automatic op(input logic w, rd, input logic [7:0] a, d,
            input logic [23:0] e);
        @(posedge core_clk_i);
        bus_i <= '{addr: a, wdata: d, wr: w, rd: rd};
        wake_evt_i <= e;
    endtask : op
    task automatic reset_and_read;
        op(0, 0, 8'h00, 8'h00, '0);
        nrst_i <= 1'h0;
        repeat (16) @(posedge core_clk_i);
        nrst_i <= 1'h1;
        foreach (addrs[k]) op(0, 1, addrs[k], 8'h00, '0);
    endtask : reset_and_read
    initial begin
        reset_and_read();
        op(1, 0, OFS_CTRL, 8'h01, '0);
        // Walk one enabled source, all others firing first
        for (int i = 0; i < 24; i++) begin
            for (int g = 0; g < 3; g++) begin
                op(1, 0, 8'(OFS_P1_EN + g), 8'h00, '0);
                op(1, 0, 8'(OFS_P1_ST + g), 8'hFF, '0);
            end
            op(1, 0, 8'(OFS_P1_EN + i / 8), 8'(1 << (i % 8)), '0);
            op(0, 0, 8'h00, 8'h00, ~(24'h1 << i));
            op(0, 0, 8'h00, 8'h00, '0);
            op(0, 1, 8'(OFS_P1_ST + i / 8), 8'h00, 24'h1 << i);
            op(0, 1, 8'(OFS_P1_EN + i / 8), 8'h00, '0);
            op(0, 0, 8'h00, 8'h00, '0);
        end
        // Random traffic, with a standby reset in mid-run
        for (int n = 0; n < 8000; n++) begin
            if (n == 4000) reset_and_read();
            r = $random(seed);
            op(r[17:16] == 2'h0, r[17:16] == 2'h1, addrs[r[2:0]], r[15:8],
                24'($random(seed) & $random(seed) & $random(seed)));
        end
        repeat (4) op(0, 0, 8'h00, 8'h00, '0);
        chk("wake_seen", 24'h1, 24'(wakes > 0));
        chk("wakes", 24'(m_wakes), 24'(wakes));
        conclude();
    end
endmodule : tb
